// >>> fsq_pkg.sv
// fsq_pkg: register map, field positions, modes and timing for the frame sequencer
// assumes a 50 MHz apb clock; printed offsets are parameter indices, byte address is 4x
package fsq_pkg;
   localparam int unsigned CLK_HZ = 50000000;
   localparam int unsigned PWM_HZ = 24000;
   localparam int unsigned PWM_DIV = CLK_HZ / PWM_HZ;
   localparam logic [11:0] PWM_DIV_M1 = 12'(PWM_DIV - 1);
   localparam logic [9:0] IDX_RSVD_A = 10'h0cf;
   localparam logic [9:0] IDX_RSVD_B = 10'h0d0;
   localparam logic [9:0] IDX_FRAME_COUNT = 10'h0d1;
   localparam logic [9:0] IDX_FRAME_POINTER = 10'h0d2;
   localparam logic [9:0] IDX_FRAME_DATA = 10'h0d3;
   localparam logic [9:0] IDX_MODE = 10'h0d4;
   localparam logic [9:0] IDX_CONFIG = 10'h0d5;
   localparam logic [9:0] IDX_STATUS = 10'h0dc;
   localparam logic [9:0] IDX_IRQ_STATUS = 10'h0e0;
   localparam logic [9:0] IDX_IRQ_CLEAR = 10'h0e1;
   localparam logic [9:0] IDX_IRQ_ENABLE = 10'h0e2;
   localparam logic [7:0] FRAME_COUNT_MIN = 8'h01;
   localparam logic [7:0] FRAME_COUNT_MAX = 8'h80;
   localparam logic [7:0] FRAME_COUNT_RST = 8'h01;
   localparam logic [7:0] FRAME_POINTER_RST = 8'h00;
   localparam logic [2:0] MODE_NULL = 3'h0;
   localparam logic [2:0] MODE_COPY = 3'h5;
   localparam logic [2:0] MODE_RUN = 3'h6;
   localparam int unsigned CFG_REPEAT_BIT = 0;
   localparam int unsigned ST_ENABLED_BIT = 8;
   localparam int unsigned ST_COPY_BIT = 9;
   localparam int unsigned ST_DONE_BIT = 10;
   localparam int unsigned IRQ_COPY_DONE = 0;
   localparam int unsigned IRQ_SEQ_DONE = 1;
   localparam int unsigned IRQ_WRAP = 2;
   typedef enum logic [1:0] {FSQ_IDLE, FSQ_COPY, FSQ_RUN, FSQ_HALT} fsq_state_t;
endpackage : fsq_pkg

// >>> fsq_pwm_tick.sv
// fsq_pwm_tick: one-cycle enable pulse at the pwm cycle rate
// assumes pclk at the rate given in fsq_pkg
`timescale 1ns/1ps
module fsq_pwm_tick (
   input wire logic pclk,
   input wire logic presetn,
   output logic tick
);
   logic [11:0] cnt_r;
   wire wrap = (cnt_r == fsq_pkg::PWM_DIV_M1);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 12'h000;
         tick <= 1'b0;
      end else begin
         cnt_r <= wrap ? 12'h000 : cnt_r + 12'h001;
         tick <= wrap;
      end
   end
endmodule : fsq_pwm_tick

// >>> fsq_frame_seq.sv
// fsq_frame_seq: apb-controlled start/stop frame store, copier and sequencer
// assumes apb master on pclk; frames step one per pwm cycle
// Behaviour
// RULE1 - frame count gives the number of frame pairs to copy and run, legal 1 to 128.
// RULE2 - software must set the frame count before entering copy mode.
// RULE3 - execution starts at frame 0 and steps until frame count minus one completes.
// RULE4 - after the last frame, frame 0 is reloaded, then halt or repeat per the repeat bit.
// RULE5 - an 8-bit frame pointer 0..255 selects the frame data word accessed.
// RULE6 - copy mode moves one frame per pwm cycle at 24 kHz.
// RULE7 - copy-in-progress is set during the copy and cleared when it finishes.
// RULE8 - with repeat set execution restarts at 0, otherwise finished is set until run re-entered; the code clears it at any mode change.
// RULE9 - pointer 2k addresses the start word of frame k and 2k+1 its stop word.
`timescale 1ns/1ps
module fsq_frame_seq (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [31:0] frame_start,
   output logic [31:0] frame_stop,
   output logic frame_valid,
   output logic irq
);
   logic [31:0] store_r [0:255];
   logic [31:0] exec_r [0:255];
   logic [7:0] count_r;
   logic [7:0] ptr_r;
   logic [2:0] mode_r;
   logic repeat_r;
   logic [7:0] loaded_r;
   logic [6:0] idx_r;
   logic [2:0] irq_st_r;
   logic [2:0] irq_en_r;
   logic pend_r;
   fsq_pkg::fsq_state_t state_r;
   logic tick;

   fsq_pwm_tick u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick)
   );

   wire [9:0] widx = paddr[11:2];
   // a write lands, and a data read steps the pointer, at the edge that sees pready high
   wire acc = psel && penable && pready;
   // read data is captured one edge earlier so it stands with pready
   wire rd_cap = psel && penable && pend_r && !pwrite;
   wire wr = acc && pwrite;
   wire rd = acc && !pwrite;
   wire hit_cnt = widx == fsq_pkg::IDX_FRAME_COUNT;
   wire hit_ptr = widx == fsq_pkg::IDX_FRAME_POINTER;
   wire hit_dat = widx == fsq_pkg::IDX_FRAME_DATA;
   wire hit_mode = widx == fsq_pkg::IDX_MODE;
   wire hit_cfg = widx == fsq_pkg::IDX_CONFIG;
   wire hit_st = widx == fsq_pkg::IDX_STATUS;
   wire hit_is = widx == fsq_pkg::IDX_IRQ_STATUS;
   wire hit_ic = widx == fsq_pkg::IDX_IRQ_CLEAR;
   wire hit_ie = widx == fsq_pkg::IDX_IRQ_ENABLE;
   wire hit_rsv = widx == fsq_pkg::IDX_RSVD_A || widx == fsq_pkg::IDX_RSVD_B;
   wire mapped = hit_cnt | hit_ptr | hit_dat | hit_mode | hit_cfg | hit_st | hit_is | hit_ic
      | hit_ie | hit_rsv;
   // frame count outside 1..128 is refused with pslverr
   wire cnt_bad = pwdata[31:0] < 32'(fsq_pkg::FRAME_COUNT_MIN)
      || pwdata[31:0] > 32'(fsq_pkg::FRAME_COUNT_MAX); // [RULE1]
   wire err = !mapped || (pwrite && hit_cnt && cnt_bad) || (pwrite && hit_st)
      || (pwrite && hit_is);
   wire [7:0] last = count_r - 8'h01; // [RULE3]
   wire at_last = {1'b0, idx_r} == last;
   wire mode_wr = wr && hit_mode && !err;
   wire [2:0] new_mode = pwdata[2:0];
   wire copy_go = mode_wr && new_mode == fsq_pkg::MODE_COPY && mode_r != fsq_pkg::MODE_COPY;
   wire run_go = mode_wr && new_mode == fsq_pkg::MODE_RUN && mode_r != fsq_pkg::MODE_RUN;
   wire leave = mode_wr && !copy_go && !run_go && new_mode != mode_r;
   wire step = tick && (state_r == fsq_pkg::FSQ_COPY || state_r == fsq_pkg::FSQ_RUN); // [RULE6]
   wire copy_end = step && state_r == fsq_pkg::FSQ_COPY && at_last;
   wire seq_end = step && state_r == fsq_pkg::FSQ_RUN && at_last;
   wire [2:0] ev = {seq_end && repeat_r, seq_end && !repeat_r, copy_end};
   wire [7:0] sidx = {idx_r, 1'b0}; // [RULE9]
   wire [31:0] status = {21'h0, state_r == fsq_pkg::FSQ_HALT, state_r == fsq_pkg::FSQ_COPY,
      state_r == fsq_pkg::FSQ_RUN, loaded_r};
   wire [31:0] rmux = hit_cnt ? {24'h0, count_r} : hit_ptr ? {24'h0, ptr_r}
      : hit_dat ? store_r[ptr_r] : hit_mode ? {29'h0, mode_r} : hit_cfg ? {31'h0, repeat_r}
      : hit_st ? status : hit_is ? {29'h0, irq_st_r} : hit_ie ? {29'h0, irq_en_r} : 32'h0;

   // apb: two wait states, pready in the third access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_r <= 1'b0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pend_r <= psel && penable && !pend_r && !pready;
         pready <= psel && penable && pend_r;
         pslverr <= psel && penable && pend_r && err;
         if (rd_cap) prdata <= err ? 32'h0 : rmux;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_r <= fsq_pkg::FRAME_COUNT_RST;
         ptr_r <= fsq_pkg::FRAME_POINTER_RST;
         mode_r <= fsq_pkg::MODE_NULL;
         repeat_r <= 1'b0;
         irq_en_r <= 3'h0;
      end else if (wr && !err) begin
         if (hit_cnt) count_r <= pwdata[7:0]; // [RULE1]
         if (hit_ptr) ptr_r <= pwdata[7:0]; // [RULE5]
         if (hit_dat) ptr_r <= ptr_r + 8'h01;
         if (hit_mode) mode_r <= new_mode;
         if (hit_cfg) repeat_r <= pwdata[fsq_pkg::CFG_REPEAT_BIT];
         if (hit_ie) irq_en_r <= pwdata[2:0];
      end else if (rd && hit_dat && !err) begin
         ptr_r <= ptr_r + 8'h01;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 256; g++) begin : g_words
         always_ff @(posedge pclk) begin
            if (wr && !err && hit_dat && ptr_r == 8'(g)) store_r[g] <= pwdata; // [RULE9]
            if (step && state_r == fsq_pkg::FSQ_COPY && sidx[7:1] == 7'(g / 2))
               exec_r[g] <= store_r[g]; // [RULE6]
         end
      end
   endgenerate

   // sequencer; the host is trusted to have set the count first [RULE2]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= fsq_pkg::FSQ_IDLE;
         idx_r <= 7'h0;
         loaded_r <= 8'h0;
      end else if (copy_go) begin
         state_r <= fsq_pkg::FSQ_COPY; // [RULE7]
         idx_r <= 7'h0;
         loaded_r <= 8'h0;
      end else if (run_go) begin
         state_r <= fsq_pkg::FSQ_RUN; // [RULE3]
         idx_r <= 7'h0;
      end else if (leave) begin
         state_r <= fsq_pkg::FSQ_IDLE;
         idx_r <= 7'h0;
      end else if (step) begin
         if (state_r == fsq_pkg::FSQ_COPY) loaded_r <= {1'b0, idx_r} + 8'h01;
         idx_r <= at_last ? 7'h0 : idx_r + 7'h01; // [RULE4]
         if (copy_end) state_r <= fsq_pkg::FSQ_IDLE; // [RULE7]
         else if (seq_end && !repeat_r) state_r <= fsq_pkg::FSQ_HALT; // [RULE8]
      end
   end

   // executed frame output, one per pwm cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_start <= 32'h0;
         frame_stop <= 32'h0;
         frame_valid <= 1'b0;
      end else begin
         frame_valid <= step && state_r == fsq_pkg::FSQ_RUN;
         if (step && state_r == fsq_pkg::FSQ_RUN) begin
            frame_start <= exec_r[sidx];
            frame_stop <= exec_r[sidx + 8'h01];
         end
      end
   end

   // sticky events: set wins over clear
   wire [2:0] clr = (wr && hit_ic) ? pwdata[2:0] : 3'h0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_st_r <= 3'h0;
         irq <= 1'b0;
      end else begin
         irq_st_r <= (irq_st_r & ~clr) | ev;
         irq <= |(((irq_st_r & ~clr) | ev) & irq_en_r);
      end
   end

   property p_count_range;
      @(posedge pclk) disable iff (!presetn)
         count_r >= fsq_pkg::FRAME_COUNT_MIN && count_r <= fsq_pkg::FRAME_COUNT_MAX;
   endproperty
   a_count_range: assert property (p_count_range) else $error("count out of range"); // [RULE1]
   property p_run_start;
      @(posedge pclk) disable iff (!presetn)
         run_go |=> state_r == fsq_pkg::FSQ_RUN && idx_r == 7'h0;
   endproperty
   a_run_start: assert property (p_run_start) else $error("run not started at frame 0"); // [RULE3]
   property p_wrap_zero;
      @(posedge pclk) disable iff (!presetn) seq_end && !mode_wr |=> idx_r == 7'h0;
   endproperty
   a_wrap_zero: assert property (p_wrap_zero) else $error("frame 0 not reloaded"); // [RULE4]
   property p_ptr_inc;
      @(posedge pclk) disable iff (!presetn)
         wr && hit_dat && !err |=> ptr_r == $past(ptr_r) + 8'h01;
   endproperty
   a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not advanced"); // [RULE5]
   property p_step_rate;
      @(posedge pclk) disable iff (!presetn) step |=> !step [*8];
   endproperty
   a_step_rate: assert property (p_step_rate) else $error("frames stepped too fast"); // [RULE6]
   property p_copy_clear;
      @(posedge pclk) disable iff (!presetn)
         copy_end && !mode_wr |=> !status[fsq_pkg::ST_COPY_BIT];
   endproperty
   a_copy_clear: assert property (p_copy_clear) else $error("copy flag stuck"); // [RULE7]
   property p_halt;
      @(posedge pclk) disable iff (!presetn)
         seq_end && !repeat_r && !mode_wr |=> state_r == fsq_pkg::FSQ_HALT ##1 !frame_valid;
   endproperty
   a_halt: assert property (p_halt) else $error("finished not raised"); // [RULE8]
   property p_repeat;
      @(posedge pclk) disable iff (!presetn)
         seq_end && repeat_r && !mode_wr |=> state_r == fsq_pkg::FSQ_RUN;
   endproperty
   a_repeat: assert property (p_repeat) else $error("repeat did not restart"); // [RULE8]
   property p_pair;
      @(posedge pclk) disable iff (!presetn)
         step && state_r == fsq_pkg::FSQ_RUN && !mode_wr
            |=> frame_valid && frame_start == $past(exec_r[sidx]);
   endproperty
   a_pair: assert property (p_pair) else $error("wrong start word"); // [RULE9]
endmodule : fsq_frame_seq

// >>> fsq_host.sv
// fsq_host: apb master model standing in for the host software
// assumes the slave answers with pready; the bench watchdog bounds every wait
`timescale 1ns/1ps
module fsq_host (
   input wire logic pclk,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end
   task automatic xfer(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
         output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released data is scrambled so a late capture shows
      pwdata <= ~wd;
   endtask : xfer
endmodule : fsq_host

// >>> testbench.sv
// testbench: host model drives the frame sequencer; frames are checked at its outputs
// assumes fsq_pkg timing, one frame every PWM_DIV clocks
`timescale 1ns/1ps
module testbench;
   localparam int TICK = fsq_pkg::PWM_DIV;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, frame_valid, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, frame_start, frame_stop;
   logic [31:0] lfsr_r = 32'h82a563ea;
   logic [31:0] fr [6];
   logic [31:0] got_q [$];
   int gap_q [$];
   int cyc = 0;
   int last = 0;
   int bad_count = 0;
   int n_checks = 0;
   always #10 pclk = ~pclk;
   fsq_host u_host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   fsq_frame_seq u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .frame_start(frame_start), .frame_stop(frame_stop),
      .frame_valid(frame_valid), .irq(irq));
   always @(posedge pclk) begin
      cyc++;
      if (frame_valid === 1'b1) begin
         got_q.push_back(frame_start);
         got_q.push_back(frame_stop);
         gap_q.push_back(cyc - last);
         last = cyc;
      end
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   function automatic logic [31:0] st_word(input logic [7:0] n, input logic cp, input logic dn);
      logic [31:0] w;
      w = {24'h000000, n};
      w[fsq_pkg::ST_COPY_BIT] = cp;
      w[fsq_pkg::ST_DONE_BIT] = dn;
      return w;
   endfunction : st_word
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask : chk
   task automatic acc(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
         input logic [31:0] msk, input logic [31:0] exp, input logic eerr);
      logic [31:0] r;
      logic e;
      u_host.xfer(wr, idx, wd, r, e);
      if (!wr) chk(r & msk, exp);
      chk({31'h0, e}, {31'h0, eerr});
   endtask : acc
   task automatic irq_is(input logic v);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk({31'h0, irq}, {31'h0, v});
   endtask : irq_is
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out
   initial begin
      repeat (80000) @(posedge pclk);
      bad_count++;
      close_out();
   end
   initial begin
      logic [31:0] cv [4];
      logic [31:0] msk;
      cv = '{32'h0, 32'h81, 32'h80, 32'h3};
      msk = 32'h0000_07ff;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      acc(0, fsq_pkg::IDX_FRAME_POINTER, 0, '1, 32'h0, 0);
      acc(0, fsq_pkg::IDX_RSVD_A, 0, '1, 32'h0, 0);
      acc(0, 10'h0ff, 0, '1, 32'h0, 1);
      acc(1, fsq_pkg::IDX_STATUS, 32'h1, 0, 0, 1);
      for (int i = 0; i < 4; i++) begin
         acc(1, fsq_pkg::IDX_FRAME_COUNT, cv[i], 0, 0, i < 2);
         acc(0, fsq_pkg::IDX_FRAME_COUNT, 0, '1, (i < 2) ? 32'h1 : cv[i], 0);
      end
      $display("test registers done");
      acc(1, fsq_pkg::IDX_FRAME_POINTER, 32'hff, 0, 0, 0);
      acc(0, fsq_pkg::IDX_FRAME_POINTER, 0, 32'hff, 32'hff, 0);
      acc(1, fsq_pkg::IDX_FRAME_POINTER, 32'h0, 0, 0, 0);
      for (int i = 0; i < 6; i++) begin
         lfsr_r = lfsr_next(lfsr_r);
         fr[i] = lfsr_r;
         acc(1, fsq_pkg::IDX_FRAME_DATA, fr[i], 0, 0, 0);
      end
      acc(0, fsq_pkg::IDX_FRAME_POINTER, 0, 32'hff, 32'h6, 0);
      acc(1, fsq_pkg::IDX_FRAME_POINTER, 32'h3, 0, 0, 0);
      acc(0, fsq_pkg::IDX_FRAME_DATA, 0, '1, fr[3], 0);
      $display("test frame store done");
      // count was set above, before copy mode is entered
      acc(1, fsq_pkg::IDX_MODE, 32'(fsq_pkg::MODE_COPY), 0, 0, 0);
      acc(0, fsq_pkg::IDX_STATUS, 0, 32'h200, 32'h200, 0);
      repeat (4 * TICK) @(posedge pclk);
      acc(0, fsq_pkg::IDX_STATUS, 0, msk, st_word(8'h3, 0, 0), 0);
      acc(0, fsq_pkg::IDX_IRQ_STATUS, 0, 32'h1, 32'h1, 0);
      acc(1, fsq_pkg::IDX_IRQ_ENABLE, 32'h2, 0, 0, 0);
      irq_is(0);
      $display("test copy done");
      acc(1, fsq_pkg::IDX_CONFIG, 32'h0, 0, 0, 0);
      acc(1, fsq_pkg::IDX_MODE, 32'(fsq_pkg::MODE_RUN), 0, 0, 0);
      repeat (5 * TICK) @(posedge pclk);
      chk(32'(got_q.size()), 32'h6);
      for (int i = 0; i < 6 && i < got_q.size(); i++) chk(got_q[i], fr[i]);
      for (int i = 1; i < gap_q.size(); i++) chk(32'(gap_q[i]), 32'(TICK));
      acc(0, fsq_pkg::IDX_STATUS, 0, 32'h400, 32'h400, 0);
      irq_is(1);
      acc(1, fsq_pkg::IDX_IRQ_CLEAR, 32'h7, 0, 0, 0);
      irq_is(0);
      acc(0, fsq_pkg::IDX_IRQ_STATUS, 0, 32'h7, 32'h0, 0);
      $display("test halt done");
      acc(1, fsq_pkg::IDX_MODE, 32'(fsq_pkg::MODE_NULL), 0, 0, 0);
      acc(1, fsq_pkg::IDX_CONFIG, 32'h1, 0, 0, 0);
      got_q.delete();
      gap_q.delete();
      acc(1, fsq_pkg::IDX_MODE, 32'(fsq_pkg::MODE_RUN), 0, 0, 0);
      repeat (7 * TICK) @(posedge pclk);
      chk(32'(got_q.size() >= 12), 32'h1);
      for (int i = 0; i < 12 && i < got_q.size(); i++) chk(got_q[i], fr[i % 6]);
      acc(0, fsq_pkg::IDX_STATUS, 0, 32'h400, 32'h0, 0);
      acc(0, fsq_pkg::IDX_IRQ_STATUS, 0, 32'h4, 32'h4, 0);
      $display("test repeat done");
      close_out();
   end
endmodule : testbench
